// >>> bench/bce_branch_eval_tb.sv
// Self-checking bench for the branch condition evaluator
`timescale 1ns/1ps
module bce_branch_eval_tb;
  import bce_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, vld = 1'b0, os32 = 1'b1;
  logic        pe = 1'b0, v86 = 1'b0, fwr = 1'b0;  // Mode and flag write
  logic [7:0]  op = 8'h00, op2 = 8'h00;            // Opcode bytes
  logic [2:0]  rg = 3'h0;                          // Reg field
  logic [31:0] disp = 32'h0, nip = 32'h0, lim = 32'h0, ptr = 32'h0;
  logic [31:0] fcnt = 32'h0, cnt;                  // Count register
  logic [1:0]  dst = 2'h0, task_state_segment = 2'h0;             // Descriptor class
  logic [3:0]  fin = 4'h0, fl;                     // Flags in and held
  logic        rdy, rv, tk, csl, tsw, flt, ill;    // Result strobes
  logic [31:0] ip;                                 // Resulting pointer
  logic [15:0] csel;                               // Resulting selector
  logic [7:0]  fvec, cyc;                          // Vector and cost
  int          n_errors = 0, cmp_count = 0, tmo = 0;

  // Core clock, 10 ns period
  initial forever #5 clk = ~clk;

  // Flag register standing in for the execution unit
  bce_flag_model fm (.clk_sys_in(clk), .rst_n_in(rst_n), .wr_in(fwr),
    .flags_in(fin), .count_in(fcnt), .flags_out(fl), .count_out(cnt));

  // Unit under test, printed less-equal condition
  bce_branch_eval uut (.clk_sys_in(clk), .rst_n_in(rst_n),
    .req_valid_in(vld), .req_ready_out(rdy), .opcode_in(op),
    .opcode2_in(op2), .modrm_reg_in(rg), .disp_in(disp),
    .next_ip_in(nip), .opsize32_in(os32), .prot_en_in(pe),
    .v86_in(v86), .code_limit_in(lim), .ptr_offset_in(ptr),
    .ptr_sel_in(16'h00A5), .dst_kind_in(dst), .tss_kind_in(task_state_segment),
    .count_register_in(cnt), .zero_flag_in(fl[3]),
    .sign_flag_in(fl[2]), .overflow_flag_in(fl[1]),
    .carry_flag_in(fl[0]), .res_valid_out(rv), .taken_out(tk),
    .instruction_pointer_out(ip), .cs_sel_out(csel),
    .cs_load_out(csl), .task_switch_out(tsw), .fault_out(flt),
    .fault_vec_out(fvec), .illegal_out(ill), .cycles_out(cyc));

  // Verdict and end of run
  task automatic finish_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // Mode, pointer and limit for following requests
  task automatic setm(input logic s32, input logic p, input logic v,
                      input logic [1:0] d, input logic [1:0] t,
                      input logic [31:0] n, input logic [31:0] l);
    @(posedge clk);
    os32 <= s32; pe <= p; v86 <= v; dst <= d; task_state_segment <= t;
    nip <= n; lim <= l;
  endtask

  // Earlier instruction writes flags and count
  task automatic setf(input logic [3:0] f, input logic [31:0] c);
    @(posedge clk);
    fwr <= 1'b1; fin <= f; fcnt <= c;
    @(posedge clk);
    fwr <= 1'b0;
  endtask

  // One request, held until accepted; cost checked unless zero
  task automatic issue(input logic [7:0] o, input logic [7:0] o2,
                       input logic [2:0] r, input logic [31:0] d,
                       input logic [31:0] p, input logic [7:0] ec);
    int n;
    n = 0;
    @(posedge clk);
    vld <= 1'b1; op <= o; op2 <= o2; rg <= r; disp <= d; ptr <= p;
    @(negedge clk);
    while (rdy !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    vld <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rv !== 1'b1 && n < 300);
    if (ec != 8'h00) begin
      chk(32'(n - 1), {24'h0, ec});
      chk({24'h0, cyc}, {24'h0, ec});
    end
  endtask

  // Count-zero jump, taken and not taken
  task automatic t_count_zero();
    setm(1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 32'h0000_1000, 32'hFFFF_FFFF);
    setf(4'h0, 32'h0);
    issue(8'hE3, 8'h00, 3'h0, 32'h0000_00F0, 32'h0, 8'h08);
    chk({31'h0, tk}, 32'h1);
    chk(ip, 32'h0000_0FF0);
    setf(4'h0, 32'h8000_0000);
    issue(8'hE3, 8'h00, 3'h0, 32'h0000_00F0, 32'h0, 8'h05);
    chk({31'h0, tk}, 32'h0);
    chk(ip, 32'h0000_1000);
  endtask

  // Every signed condition, short and near, over all zero, sign and overflow mixes
  task automatic t_jcc();
    logic [7:0] sop [4];
    logic [7:0] nop [4];
    logic       z, s, o, e;
    sop = '{8'h7F, 8'h7D, 8'h7C, 8'h7E};
    nop = '{8'h84, 8'h8D, 8'h8C, 8'h8E};
    setm(1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 32'h0000_1000, 32'hFFFF_FFFF);
    for (int f = 0; f < 8; f++) begin
      z = f[2];
      s = f[1];
      o = f[0];
      setf({z, s, o, ~s}, 32'h1);  // Carry set against sign
      for (int k = 0; k < 8; k++) begin
        case (k % 4)
          0: e = !z && (s == o);
          1: e = (s == o);
          2: e = (s != o);
          default: e = z && (s != o);
        endcase
        if (k < 4) begin
          issue(sop[k], 8'h00, 3'h0, 32'h0000_0004, 32'h0,
                e ? 8'h03 : 8'h01);
        end else begin
          issue(8'h0F, nop[k - 4], 3'h0, 32'hFFFF_FF00, 32'h0,
                e ? 8'h03 : 8'h01);
        end
        chk({31'h0, tk}, {31'h0, e});
        chk(ip, !e ? 32'h1000 : (k < 4 ? 32'h1004 : 32'h0F00));
      end
    end
  endtask

  // Relative and near indirect jumps, 16-bit wrap, unknown opcode
  task automatic t_rel();
    setm(1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 32'h0000_FFF0, 32'hFFFF_FFFF);
    issue(8'hEB, 8'h00, 3'h0, 32'h0000_0020, 32'h0, 8'h03);
    chk(ip, 32'h0000_0010);
    issue(8'hE9, 8'h00, 3'h0, 32'h0000_0020, 32'h0, 8'h03);
    chk(ip, 32'h0000_0010);
    setm(1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 32'h0000_FFF0, 32'hFFFF_FFFF);
    issue(8'hE9, 8'h00, 3'h0, 32'h0001_0000, 32'h0, 8'h03);
    chk(ip, 32'h0001_FFF0);
    issue(8'hFF, 8'h00, 3'h4, 32'h0, 32'h8765_4321, 8'h05);
    chk(ip, 32'h8765_4321);
    issue(8'h90, 8'h00, 3'h0, 32'h0, 32'h0, 8'h01);
    chk({31'h0, ill}, 32'h1);
    chk(ip, 32'h0000_FFF0);
  endtask

  // Limit overrun in protected mode, boundary, and in v86
  task automatic t_limit();
    setm(1'b1, 1'b1, 1'b0, 2'h0, 2'h0, 32'h0000_1000, 32'h0000_1FFF);
    issue(8'hE9, 8'h00, 3'h0, 32'h0000_2000, 32'h0, 8'h00);
    chk({tk, flt, csl}, 32'h2);
    chk({24'h0, fvec}, 32'h0000_000D);
    chk(ip, 32'h0000_1000);
    issue(8'hE9, 8'h00, 3'h0, 32'h0000_0FFF, 32'h0, 8'h03);
    chk({tk, flt}, 32'h2);
    chk(ip, 32'h0000_1FFF);
    setm(1'b1, 1'b1, 1'b1, 2'h0, 2'h0, 32'h0000_1000, 32'h0000_1FFF);
    issue(8'hE9, 8'h00, 3'h0, 32'h0000_2000, 32'h0, 8'h03);
    chk({tk, flt}, 32'h2);
    chk(ip, 32'h0000_3000);
  endtask

  // Far forms: op, prot, dst, tss, cost
  task automatic t_far();
    logic [27:0] t [12];
    t = '{28'hEA_0_3_0_11, 28'hEA_1_0_0_13, 28'hFF_0_0_0_0D,
          28'hFF_1_0_0_12, 28'hEA_1_1_0_20, 28'hFF_1_1_0_1F,
          28'hEA_1_3_0_F1, 28'hEA_1_3_1_DE, 28'hEA_1_3_2_DB,
          28'hEA_1_2_0_F2, 28'hFF_1_3_0_F0, 28'hFF_1_2_1_DE};
    for (int i = 0; i < 12; i++) begin
      setm(1'b1, t[i][16], 1'b0, t[i][13:12], t[i][9:8],
           32'h0000_1000, 32'hFFFF_FFFF);
      issue(t[i][27:20], 8'h00, 3'h5, 32'h0, 32'h1234_5678,
            t[i][7:0]);
      chk({31'h0, tsw}, {31'h0, t[i][16] & t[i][13]});
      chk({31'h0, csl}, 32'h1);
      if (!(t[i][16] & t[i][13])) begin
        chk(ip, 32'h1234_5678);
        chk({16'h0, csel}, 32'h0000_00A5);
      end
    end
  endtask

  // Hang guard
  always @(posedge clk) begin
    tmo <= tmo + 1;
    if (tmo == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_count_zero();
    t_jcc();
    t_rel();
    t_limit();
    t_far();
    finish_test();
  end
endmodule

// >>> bench/bce_flag_model.sv
// Flag and count register model of the execution unit
`timescale 1ns/1ps
module bce_flag_model (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // Update from a preceding instruction
  input  wire logic        wr_in,
  input  wire logic [3:0]  flags_in,
  input  wire logic [31:0] count_in,
  // Held state seen by the branch logic, {zero, sign, overflow, carry}
  output logic [3:0]       flags_out,
  output logic [31:0]      count_out
);
  // State only moves on reset or an earlier write, never during a branch
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_out <= 4'h0;
      count_out <= 32'h0;
    end else if (wr_in) begin  // Written by an earlier instruction
      flags_out <= flags_in;
      count_out <= count_in;
    end
  end
endmodule

// >>> design/bce_branch_eval.sv
// Branch decode, resolution and cycle accounting
`timescale 1ns/1ps

module bce_branch_eval
  import bce_pkg::*;
#(
  parameter bit LE_USE_OR = 1'b0   // Less-equal as OR of ZF and SF!=OF
) (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // Request from the decode pipeline
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic [7:0]  opcode_in,
  input  wire logic [7:0]  opcode2_in,
  input  wire logic [2:0]  modrm_reg_in,
  input  wire logic [31:0] disp_in,
  input  wire logic [31:0] next_ip_in,
  input  wire logic        opsize32_in,
  input  wire logic        prot_en_in,
  input  wire logic        v86_in,
  input  wire logic [31:0] code_limit_in,
  // Far pointer and descriptor class
  input  wire logic [31:0] ptr_offset_in,
  input  wire logic [15:0] ptr_sel_in,
  input  wire logic [1:0]  dst_kind_in,
  input  wire logic [1:0]  tss_kind_in,
  // Execution unit state
  input  wire logic [31:0] count_register_in,
  input  wire logic        zero_flag_in,
  input  wire logic        sign_flag_in,
  input  wire logic        overflow_flag_in,
  input  wire logic        carry_flag_in,
  // Result
  output logic             res_valid_out,
  output logic             taken_out,
  output logic [31:0]      instruction_pointer_out,
  output logic [15:0]      cs_sel_out,
  output logic             cs_load_out,
  output logic             task_switch_out,
  output logic             fault_out,
  output logic [7:0]       fault_vec_out,
  output logic             illegal_out,
  output logic [7:0]       cycles_out
);

  // Sequencer states
  typedef enum logic [1:0] {BCE_IDLE, BCE_BUSY} bce_state_t;

  bce_state_t  state_q;         // Sequencer state
  logic [7:0]  cnt_q;           // Remaining cycles
  logic        accept;          // Request taken this cycle
  logic        prot_mode;       // Protected, not virtual-8086
  // Decode results
  logic        is_cz;           // Count-zero jump
  logic        is_jcc;          // Signed conditional
  logic        is_rel;          // Short or near relative jump
  logic        is_nind;         // Near indirect
  logic        is_fdir;         // Far direct
  logic        is_find;         // Far indirect
  logic        near_form;       // Uses 16/32-bit displacement
  logic        cond_true;       // Condition met
  logic        take;            // Control transfers
  logic        far_x;           // Far transfer
  logic [31:0] sdisp;           // Sign-extended displacement
  logic [31:0] tgt_raw;         // Target before masking
  logic [31:0] tgt;             // Target after masking
  logic        over_limit;      // Target beyond code limit
  logic [7:0]  ts_cyc;          // Task switch time
  logic [7:0]  cyc_d;           // Cost of this instruction
  logic        cf_unused;       // Carry plays no part here

  // Handshake: only idle accepts
  assign req_ready_out = (state_q == BCE_IDLE);
  assign accept        = req_valid_in & req_ready_out;
  assign prot_mode     = prot_en_in & ~v86_in;
  assign cf_unused     = carry_flag_in;

  // Opcode decode
  always_comb begin
    is_cz   = (opcode_in == OP_CNT_ZERO);
    near_form = 1'b0;
    is_jcc  = 1'b0;
    // Short conditional forms
    if (opcode_in == OP_SGT_SHORT || opcode_in == OP_SGE_SHORT ||
        opcode_in == OP_SLT_SHORT || opcode_in == OP_SLE_SHORT) begin
      is_jcc = 1'b1;
    end
    // Near conditional forms; greater at printed code
    if (opcode_in == OP_ESCAPE &&
        (opcode2_in == OP_SGT_NEAR || opcode2_in == OP_SGE_NEAR ||
         opcode2_in == OP_SLT_NEAR || opcode2_in == OP_SLE_NEAR)) begin
      is_jcc    = 1'b1;
      near_form = 1'b1;
    end
    is_rel  = (opcode_in == OP_JMP_SHORT) || (opcode_in == OP_JMP_NEAR);
    if (opcode_in == OP_JMP_NEAR) begin
      near_form = 1'b1;
    end
    is_nind = (opcode_in == OP_GROUP5) && (modrm_reg_in == REG_NEAR_IND);
    is_fdir = (opcode_in == OP_JMP_FAR);
    is_find = (opcode_in == OP_GROUP5) && (modrm_reg_in == REG_FAR_IND);
  end

  // Condition evaluation from flags left by earlier code
  always_comb begin
    cond_true = 1'b0;
    if (is_cz) begin
      cond_true = (count_register_in == 32'h00000000);
    end else if (opcode_in == OP_SGT_SHORT ||
                 (near_form && opcode2_in == OP_SGT_NEAR)) begin
      // Signed greater
      cond_true = ~zero_flag_in & (sign_flag_in == overflow_flag_in);
    end else if (opcode_in == OP_SGE_SHORT ||
                 (near_form && opcode2_in == OP_SGE_NEAR)) begin
      cond_true = (sign_flag_in == overflow_flag_in);
    end else if (opcode_in == OP_SLT_SHORT ||
                 (near_form && opcode2_in == OP_SLT_NEAR)) begin
      cond_true = (sign_flag_in != overflow_flag_in);
    end else if (LE_USE_OR) begin
      // Conventional less-equal
      cond_true = zero_flag_in | (sign_flag_in != overflow_flag_in);
    end else begin
      // Less-equal as printed
      cond_true = zero_flag_in & (sign_flag_in != overflow_flag_in);
    end
  end

  // Target arithmetic
  always_comb begin
    // Short forms carry 8 bits, near forms 16 or 32
    if (!near_form) begin
      sdisp = {{24{disp_in[7]}}, disp_in[7:0]};
    end else if (opsize32_in) begin
      sdisp = disp_in;
    end else begin
      sdisp = {{16{disp_in[15]}}, disp_in[15:0]};
    end
    far_x = is_fdir | is_find;
    take  = 1'b1;
    if (is_cz || is_jcc) begin
      take = cond_true;
    end
    // Pick the raw destination
    if (!take) begin
      tgt_raw = next_ip_in;
    end else if (is_nind || far_x) begin
      tgt_raw = ptr_offset_in;
    end else begin
      tgt_raw = next_ip_in + sdisp;
    end
    // Narrow operand size clears the upper half
    tgt = opsize32_in ? tgt_raw : (tgt_raw & MASK_16);
    over_limit = prot_mode && take && (tgt > code_limit_in);
  end

  // Task switch time by segment format
  always_comb begin
    unique case (bce_tss_t'(tss_kind_in))
      BCE_TSS_NATIVE: ts_cyc = CYC_TS_NAT;
      BCE_TSS_OLD16:  ts_cyc = CYC_TS_OLD;
      BCE_TSS_V86:    ts_cyc = CYC_TS_V86;
      default:        ts_cyc = CYC_TS_NAT;
    endcase
  end

  // Cycle cost of the request
  always_comb begin
    cyc_d = CYC_ILLEGAL;
    if (is_cz) begin
      cyc_d = cond_true ? CYC_CZ_TRUE : CYC_CZ_FALSE;
    end else if (is_jcc) begin
      cyc_d = cond_true ? CYC_JCC_TRUE : CYC_JCC_FALS;
    end else if (is_rel) begin
      cyc_d = CYC_JMP_REL;
    end else if (is_nind) begin
      cyc_d = CYC_NEAR_IND;
    end else if (far_x && !prot_mode) begin
      cyc_d = is_fdir ? CYC_FAR_RM : CYC_FIND_RM;
    end else if (far_x) begin
      unique case (bce_dst_t'(dst_kind_in))
        BCE_DST_CODE: begin
          cyc_d = is_fdir ? CYC_FAR_PM : CYC_FIND_PM;
        end
        BCE_DST_CALL_GATE: begin
          cyc_d = is_fdir ? CYC_GATE_IMM : CYC_GATE_MEM;
        end
        BCE_DST_TSS: begin
          cyc_d = 8'((is_fdir ? CYC_TSS_IMM : CYC_TSS_MEM) + ts_cyc);
        end
        BCE_DST_TASK_GATE: begin
          cyc_d = 8'((is_fdir ? CYC_TGT_IMM : CYC_TGT_MEM) + ts_cyc);
        end
      endcase
    end
  end

  // Sequencer: hold the result back for the instruction's cost
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= BCE_IDLE;
      cnt_q   <= 8'h00;
    end else begin
      unique case (state_q)
        BCE_IDLE: begin
          if (accept) begin
            state_q <= BCE_BUSY;
            cnt_q   <= 8'(cyc_d - 8'h01);
          end
        end
        BCE_BUSY: begin
          if (cnt_q == 8'h00) begin
            state_q <= BCE_IDLE;
          end else begin
            cnt_q <= 8'(cnt_q - 8'h01);
          end
        end
      endcase
    end
  end

  // Completion pulse
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      res_valid_out <= 1'b0;
    end else begin
      res_valid_out <= (state_q == BCE_BUSY) && (cnt_q == 8'h00);
    end
  end

  // Result capture at acceptance
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      taken_out               <= 1'b0;
      instruction_pointer_out <= 32'h00000000;
      cs_sel_out              <= SEL_RST;
      cs_load_out             <= 1'b0;
      task_switch_out         <= 1'b0;
      fault_out               <= 1'b0;
      fault_vec_out           <= 8'h00;
      illegal_out             <= 1'b0;
      cycles_out              <= 8'h00;
    end else if (accept) begin
      cycles_out  <= cyc_d;
      illegal_out <= ~(is_cz | is_jcc | is_rel | is_nind | far_x);
      if (!(is_cz | is_jcc | is_rel | is_nind | far_x)) begin
        // Unknown opcode: nothing moves
        taken_out               <= 1'b0;
        instruction_pointer_out <= next_ip_in;
        cs_load_out             <= 1'b0;
        task_switch_out         <= 1'b0;
        fault_out               <= 1'b0;
        fault_vec_out           <= 8'h00;
      end else if (over_limit) begin
        // Fault replaces the transfer
        taken_out               <= 1'b0;
        instruction_pointer_out <= next_ip_in;
        cs_load_out             <= 1'b0;
        task_switch_out         <= 1'b0;
        fault_out               <= 1'b1;
        fault_vec_out           <= VEC_GP;
      end else begin
        taken_out               <= take;
        instruction_pointer_out <= tgt;
        cs_sel_out              <= ptr_sel_in;
        cs_load_out             <= far_x;
        // Flags reload only through a task switch
        task_switch_out <= far_x && prot_mode &&
          (dst_kind_in == BCE_DST_TSS || dst_kind_in == BCE_DST_TASK_GATE);
        fault_out               <= 1'b0;
        fault_vec_out           <= 8'h00;
      end
    end
  end

  // Checks of timing and results
  sequence s_done_taken;
    res_valid_out && (taken_out || fault_out);
  endsequence
  sequence s_done_not;
    res_valid_out && !taken_out && !fault_out;
  endsequence

  property p_cz_true;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      accept && is_cz && cond_true |-> ##9 s_done_taken;
  endproperty

  property p_cz_false;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      accept && is_cz && !cond_true |-> ##6 s_done_not;
  endproperty

  AST_CZ_TAKEN: assert property (p_cz_true)
    else $error("count-zero taken timing wrong");

  AST_CZ_NOT: assert property (p_cz_false)
    else $error("count-zero untaken timing wrong");

  AST_MASK16: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      accept && !opsize32_in |=> instruction_pointer_out[31:16] == 16'h0)
    else $error("narrow target not masked");

  AST_NO_FLAGS: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      accept && is_jcc |=> !task_switch_out)
    else $error("conditional branch touched flags");

  AST_GP: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      accept && over_limit |=> fault_out && fault_vec_out == VEC_GP
      && !taken_out)
    else $error("limit fault missing");

  AST_GREATER: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      accept && opcode_in == OP_SGT_SHORT && !zero_flag_in &&
      sign_flag_in == overflow_flag_in |-> ##4 s_done_taken)
    else $error("greater branch not taken in 3");

  AST_LESS: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      accept && opcode_in == OP_SLT_SHORT &&
      sign_flag_in == overflow_flag_in |-> ##2 s_done_not)
    else $error("less branch wrongly taken");

  AST_REL3: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      accept && is_rel |-> ##1 !res_valid_out [*3] ##1 res_valid_out)
    else $error("relative jump not 3 cycles");

  AST_FAR_RM: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      accept && is_fdir && !prot_mode |-> ##18 res_valid_out)
    else $error("far direct real mode not 17");

  AST_UNTAKEN_IP: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      accept && is_jcc && !cond_true |=>
      instruction_pointer_out == ($past(opsize32_in) ? $past(next_ip_in)
      : ($past(next_ip_in) & MASK_16)))
    else $error("untaken branch moved pointer oddly");

endmodule

// >>> design/bce_pkg.sv
// Constants and types for the branch condition evaluator
package bce_pkg;
  // Opcode bytes
  localparam logic [7:0] OP_CNT_ZERO  = 8'hE3;
  localparam logic [7:0] OP_SGT_SHORT = 8'h7F;
  localparam logic [7:0] OP_SGE_SHORT = 8'h7D;
  localparam logic [7:0] OP_SLT_SHORT = 8'h7C;
  localparam logic [7:0] OP_SLE_SHORT = 8'h7E;
  localparam logic [7:0] OP_ESCAPE    = 8'h0F;
  localparam logic [7:0] OP_SGT_NEAR  = 8'h84;
  localparam logic [7:0] OP_SGE_NEAR  = 8'h8D;
  localparam logic [7:0] OP_SLT_NEAR  = 8'h8C;
  localparam logic [7:0] OP_SLE_NEAR  = 8'h8E;
  localparam logic [7:0] OP_JMP_SHORT = 8'hEB;
  localparam logic [7:0] OP_JMP_NEAR  = 8'hE9;
  localparam logic [7:0] OP_JMP_FAR   = 8'hEA;
  localparam logic [7:0] OP_GROUP5    = 8'hFF;
  localparam logic [2:0] REG_NEAR_IND = 3'h4;
  localparam logic [2:0] REG_FAR_IND  = 3'h5;
  // Cycle costs
  localparam logic [7:0] CYC_CZ_TRUE  = 8'h08;
  localparam logic [7:0] CYC_CZ_FALSE = 8'h05;
  localparam logic [7:0] CYC_JCC_TRUE = 8'h03;
  localparam logic [7:0] CYC_JCC_FALS = 8'h01;
  localparam logic [7:0] CYC_JMP_REL  = 8'h03;
  localparam logic [7:0] CYC_NEAR_IND = 8'h05;
  localparam logic [7:0] CYC_FAR_RM   = 8'h11;
  localparam logic [7:0] CYC_FAR_PM   = 8'h13;
  localparam logic [7:0] CYC_FIND_RM  = 8'h0D;
  localparam logic [7:0] CYC_FIND_PM  = 8'h12;
  localparam logic [7:0] CYC_GATE_IMM = 8'h20;
  localparam logic [7:0] CYC_GATE_MEM = 8'h1F;
  localparam logic [7:0] CYC_TSS_IMM  = 8'h2A;
  localparam logic [7:0] CYC_TGT_IMM  = 8'h2B;
  localparam logic [7:0] CYC_TSS_MEM  = 8'h29;
  localparam logic [7:0] CYC_TGT_MEM  = 8'h2A;
  localparam logic [7:0] CYC_TS_NAT   = 8'hC7;
  localparam logic [7:0] CYC_TS_OLD   = 8'hB4;
  localparam logic [7:0] CYC_TS_V86   = 8'hB1;
  localparam logic [7:0] CYC_ILLEGAL  = 8'h01;
  // Fault and masking
  localparam logic [7:0]  VEC_GP   = 8'h0D;
  localparam logic [31:0] MASK_16  = 32'h0000FFFF;
  localparam logic [15:0] SEL_RST  = 16'h0000;
  // Protected mode destination kinds
  typedef enum logic [1:0] {
    BCE_DST_CODE, BCE_DST_CALL_GATE, BCE_DST_TASK_GATE, BCE_DST_TSS
  } bce_dst_t;
  // Task segment formats
  typedef enum logic [1:0] {
    BCE_TSS_NATIVE, BCE_TSS_OLD16, BCE_TSS_V86
  } bce_tss_t;
endpackage
